// ===== verilog/sfw_pkg.sv
package sfw_pkg;
    // trigger clock and documented storage rates
    localparam int CLK_HZ      = 40_000_000;
    localparam int RATE_104_HZ = 104;
    localparam int RATE_208_HZ = 208;
    localparam int DIV_104     = CLK_HZ / RATE_104_HZ;
    localparam int DIV_208     = CLK_HZ / RATE_208_HZ;
    localparam int DIV_W       = 20;

    localparam logic [3:0] RATE_SEL_104 = 4'h4;
    localparam logic [3:0] RATE_SEL_208 = 4'h5;

    localparam logic [2:0] DEC_BY1 = 3'h1;
    localparam logic [2:0] DEC_BY2 = 3'h2;
    localparam logic [2:0] DEC_BY4 = 3'h4;

    localparam int NUM_SETS = 4;
    localparam int AXES     = 3;
    localparam int WORDS    = NUM_SETS * AXES;
    localparam int WORD_W   = 16;
    localparam int PAT_W    = 10;
    localparam int WM_W     = 12;
    localparam int WM_LO_W  = 8;
    localparam int DEC_W    = 3;
    localparam int IRQ_W    = 3;

    // byte offsets on the register bus
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h00;
    localparam logic [7:0] OFS_CTRL_TWO   = 8'h04;
    localparam logic [7:0] OFS_CTRL_THREE = 8'h08;
    localparam logic [7:0] OFS_CTRL_FOUR  = 8'h0C;
    localparam logic [7:0] OFS_CTRL_FIVE  = 8'h10;
    localparam logic [7:0] OFS_COMMON_C4  = 8'h14;
    localparam logic [7:0] OFS_STATUS_ONE = 8'h18;
    localparam logic [7:0] OFS_STATUS_TWO = 8'h1C;
    localparam logic [7:0] OFS_PATTERN    = 8'h20;
    localparam logic [7:0] OFS_DATA_OUT   = 8'h24;
    localparam logic [7:0] OFS_IRQ_STAT   = 8'h28;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h2C;

    // field positions
    localparam int DEC_HI_LSB   = 3;
    localparam int FIVE_EN_BIT  = 4;
    localparam int C4_HALT_BIT  = 0;
    localparam int ST2_WM_BIT   = 0;
    localparam int ST2_FULL_BIT = 1;
    localparam int ST2_EMPTY_BIT = 2;
    localparam int ST2_OVR_BIT  = 3;
    localparam int IRQ_WM_BIT   = 0;
    localparam int IRQ_FULL_BIT = 1;
    localparam int IRQ_OVR_BIT  = 2;

    // reset values
    localparam logic [WM_W-1:0]  WM_RST   = 12'h000;
    localparam logic [3:0]       RATE_RST = 4'h0;
    localparam logic [DEC_W-1:0] DEC_RST  = 3'h0;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        SFW_IDLE  = 2'b01,
        SFW_WRITE = 2'b10
    } sfw_seq_e;
endpackage

// ===== verilog/sfw_fifo.sv
// Operation
// - code 0100b selects a 104 Hz trigger
// - code 0101b selects a 208 Hz trigger
// - decimation codes store every 1, 2, 4 triggers
// - equal rates give six words, index 0..5
// - gyro twice accel rate repeats every 9
// - third pattern repeats every 21 words
// - third set words follow accelerometer words
// - 12-bit watermark split over two registers
// - watermark counts 16-bit words, 0 to 4095
// - watermark flag when count reaches level
// - halt bit limits depth to watermark
// - halt clear keeps storing until full
// - halt set stops at exactly watermark words
// - first sequence holds every enabled set
// - 10-bit index wraps with the pattern
// - data read returns oldest word, advances
`timescale 1ns/100ps
module sfw_fifo import sfw_pkg::*; #(
    parameter int DEPTH        = 4096,
    parameter int TRIG_DIV_104 = DIV_104,
    parameter int TRIG_DIV_208 = DIV_208
) (
    input  wire logic                ref_clk,        // system clock
    input  wire logic                rstn,           // async reset, low
    input  wire logic                hsel,           // slave select
    input  wire logic [31:0]         haddr,          // byte address
    input  wire logic [1:0]          htrans,         // transfer type
    input  wire logic                hwrite,         // write when high
    input  wire logic [2:0]          hsize,          // word only
    input  wire logic [31:0]         hwdata,         // write data
    input  wire logic                hready,         // bus ready
    output logic      [31:0]         hrdata,         // read data
    output logic                     hreadyout,      // slave ready
    output logic                     hresp,          // always okay
    output logic                     irq,            // level interrupt
    input  wire logic [AXES*WORD_W-1:0] first_set_xyz,  // z,y,x words
    input  wire logic [AXES*WORD_W-1:0] second_set_xyz, // z,y,x words
    input  wire logic [AXES*WORD_W-1:0] third_set_xyz,  // z,y,x words
    input  wire logic [AXES*WORD_W-1:0] fourth_set_xyz  // z,y,x words
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam int CNT_W = PTR_W + 1;
    localparam int MEM_W = PAT_W + WORD_W;

    if (DEPTH < 8 || DEPTH > 4096 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two from 8 to 4096");
    end
    // a tick that lands inside a running sequence would be lost
    if (TRIG_DIV_208 <= WORDS || TRIG_DIV_104 <= WORDS ||
        TRIG_DIV_104 >= (1 << DIV_W) || TRIG_DIV_208 >= (1 << DIV_W)) begin : g_bad_div
        $error("trigger dividers out of range");
    end

    typedef struct packed {
        sfw_seq_e                        seq;
        logic [WM_W-1:0]                 wm_level;
        logic [NUM_SETS-1:0][DEC_W-1:0]  dec;
        logic [3:0]                      rate_sel;
        logic                            fifo_en;
        logic                            halt;
        logic [IRQ_W-1:0]                irq_stat;
        logic [IRQ_W-1:0]                irq_mask;
        logic                            irq;
        logic                            wr_pend;
        logic [7:0]                      wr_addr;
        logic [31:0]                     hrdata;
        logic                            hready;
        logic                            hresp;
        logic [DIV_W-1:0]                div_cnt;
        logic [NUM_SETS-1:0][1:0]        dec_cnt;
        logic [WORDS-1:0][WORD_W-1:0]    snap;
        logic [NUM_SETS-1:0]             store;
        logic [3:0]                      widx;
        logic [PAT_W-1:0]                pat_w;
        logic [PTR_W-1:0]                wr_ptr;
        logic [PTR_W-1:0]                rd_ptr;
        logic [CNT_W-1:0]                count;
        logic [WORD_W-1:0]               last_word;
        logic                            wm_prev;
        logic                            full_prev;
    } sfw_state_s;

    sfw_state_s       s_q;
    sfw_state_s       s_d;
    logic [MEM_W-1:0] mem [DEPTH];
    logic             mem_we;
    logic [MEM_W-1:0] mem_wd;

    function automatic logic [DIV_W-1:0] trig_period(input logic [3:0] sel);
        case (sel)
            RATE_SEL_104: trig_period = DIV_W'(TRIG_DIV_104);
            RATE_SEL_208: trig_period = DIV_W'(TRIG_DIV_208);
            default:      trig_period = '0;
        endcase
    endfunction

    function automatic logic [2:0] dec_factor(input logic [DEC_W-1:0] code);
        case (code)
            DEC_BY1: dec_factor = 3'h1;
            DEC_BY2: dec_factor = 3'h2;
            DEC_BY4: dec_factor = 3'h4;
            default: dec_factor = 3'h0;
        endcase
    endfunction

    function automatic logic [1:0] set_of(input logic [3:0] w);
        if (w < 4'h3) begin
            set_of = 2'h0;
        end else if (w < 4'h6) begin
            set_of = 2'h1;
        end else if (w < 4'h9) begin
            set_of = 2'h2;
        end else begin
            set_of = 2'h3;
        end
    endfunction

    always_comb begin
        logic                  acc;
        logic                  pop;
        logic                  flush;
        logic                  full;
        logic                  empty;
        logic                  wm_flag;
        logic                  ovr;
        logic [WM_W:0]         cnt_x;
        logic [WM_W:0]         lim_x;
        logic [DIV_W-1:0]      period;
        logic                  tick;
        logic [2:0]            f;
        logic [NUM_SETS-1:0]   en_mask;
        logic [NUM_SETS-1:0]   st_mask;
        logic [MEM_W-1:0]      head;
        logic [IRQ_W-1:0]      clr;
        logic [IRQ_W-1:0]      ev;
        s_d     = s_q;
        acc     = hsel && hready && htrans == HTRANS_NONSEQ;
        pop     = 1'b0;
        flush   = 1'b0;
        ovr     = 1'b0;
        clr     = '0;
        ev      = '0;
        mem_we  = 1'b0;
        mem_wd  = '0;
        en_mask = '0;
        st_mask = '0;
        f       = '0;
        head    = mem[s_q.rd_ptr];
        empty   = s_q.count == '0;
        cnt_x   = (WM_W+1)'(s_q.count);
        // the halt bit turns the watermark into the usable depth
        lim_x   = s_q.halt ? {1'b0, s_q.wm_level} : (WM_W+1)'(DEPTH);
        full    = cnt_x >= lim_x;
        wm_flag = cnt_x >= {1'b0, s_q.wm_level};

        // storage trigger divider
        period = trig_period(s_q.rate_sel);
        tick   = 1'b0;
        if (period == '0 || !s_q.fifo_en) begin
            s_d.div_cnt = '0;
        end else if (s_q.div_cnt >= period - 1'b1) begin
            s_d.div_cnt = '0;
            tick        = 1'b1;
        end else begin
            s_d.div_cnt = s_q.div_cnt + 1'b1;
        end

        case (s_q.seq)
            SFW_IDLE: begin
                if (tick) begin
                    for (int k = 0; k < NUM_SETS; k++) begin
                        f          = dec_factor(s_q.dec[k]);
                        en_mask[k] = f != '0;
                        // counters start at zero, so the first trigger takes every enabled set
                        st_mask[k] = en_mask[k] && s_q.dec_cnt[k] == '0;
                        if (!en_mask[k] || s_q.dec_cnt[k] == 2'(f - 1'b1)) begin
                            s_d.dec_cnt[k] = '0;
                        end else begin
                            s_d.dec_cnt[k] = s_q.dec_cnt[k] + 1'b1;
                        end
                    end
                    if (st_mask != '0) begin
                        s_d.store = st_mask;
                        s_d.snap  = {fourth_set_xyz, third_set_xyz, second_set_xyz, first_set_xyz};
                        s_d.widx  = '0;
                        s_d.seq   = SFW_WRITE;
                        // all enabled sets due again means the pattern starts over
                        if (st_mask == en_mask) begin
                            s_d.pat_w = '0;
                        end
                    end
                end
            end
            SFW_WRITE: begin
                // set order 1..4, x,y,z each, so set 3 lands after set 2
                if (s_q.store[set_of(s_q.widx)]) begin
                    if (full) begin
                        ovr = 1'b1;
                    end else begin
                        mem_we = 1'b1;
                        mem_wd = {s_q.pat_w, s_q.snap[s_q.widx]};
                    end
                    // index advances even on a dropped word so tags stay aligned
                    s_d.pat_w = s_q.pat_w + 1'b1;
                end
                s_d.widx = s_q.widx + 1'b1;
                if (s_q.widx == 4'(WORDS - 1)) begin
                    s_d.seq = SFW_IDLE;
                end
            end
            default: begin
                s_d.seq = SFW_IDLE;
            end
        endcase

        // bus: reads answer in the address phase edge, writes take one wait
        s_d.hresp = 1'b0;
        if (s_q.wr_pend) begin
            s_d.wr_pend = 1'b0;
            s_d.hready  = 1'b1;
            case (s_q.wr_addr)
                OFS_CTRL_ONE: begin
                    s_d.wm_level[WM_LO_W-1:0] = hwdata[WM_LO_W-1:0];
                end
                OFS_CTRL_TWO: begin
                    s_d.wm_level[WM_W-1:WM_LO_W] = hwdata[WM_W-WM_LO_W-1:0];
                end
                OFS_CTRL_THREE: begin
                    s_d.dec[0] = hwdata[DEC_W-1:0];
                    s_d.dec[1] = hwdata[DEC_HI_LSB +: DEC_W];
                    flush      = 1'b1;
                end
                OFS_CTRL_FOUR: begin
                    s_d.dec[2] = hwdata[DEC_W-1:0];
                    s_d.dec[3] = hwdata[DEC_HI_LSB +: DEC_W];
                    flush      = 1'b1;
                end
                OFS_CTRL_FIVE: begin
                    s_d.rate_sel = hwdata[3:0];
                    s_d.fifo_en  = hwdata[FIVE_EN_BIT];
                    flush        = 1'b1;
                end
                OFS_COMMON_C4: begin
                    s_d.halt = hwdata[C4_HALT_BIT];
                end
                OFS_IRQ_STAT: begin
                    clr = hwdata[IRQ_W-1:0];
                end
                OFS_IRQ_MASK: begin
                    s_d.irq_mask = hwdata[IRQ_W-1:0];
                end
                default: begin
                end
            endcase
        end else if (acc && hwrite) begin
            s_d.wr_pend = 1'b1;
            s_d.wr_addr = haddr[7:0];
            s_d.hready  = 1'b0;
        end else if (acc) begin
            case (haddr[7:0])
                OFS_CTRL_ONE:   s_d.hrdata = 32'(s_q.wm_level[WM_LO_W-1:0]);
                OFS_CTRL_TWO:   s_d.hrdata = 32'(s_q.wm_level[WM_W-1:WM_LO_W]);
                OFS_CTRL_THREE: s_d.hrdata = 32'({s_q.dec[1], s_q.dec[0]});
                OFS_CTRL_FOUR:  s_d.hrdata = 32'({s_q.dec[3], s_q.dec[2]});
                OFS_CTRL_FIVE:  s_d.hrdata = 32'({s_q.fifo_en, s_q.rate_sel});
                OFS_COMMON_C4:  s_d.hrdata = 32'(s_q.halt);
                OFS_STATUS_ONE: s_d.hrdata = 32'(s_q.count);
                OFS_STATUS_TWO: s_d.hrdata = 32'({s_q.irq_stat[IRQ_OVR_BIT], empty, full, wm_flag});
                // with data stored the head tag names the next word out
                OFS_PATTERN:    s_d.hrdata = 32'(empty ? s_q.pat_w : head[MEM_W-1:WORD_W]);
                OFS_DATA_OUT: begin
                    if (s_q.fifo_en && !empty) begin
                        pop            = 1'b1;
                        s_d.hrdata     = 32'(head[WORD_W-1:0]);
                        s_d.last_word  = head[WORD_W-1:0];
                    end else begin
                        s_d.hrdata = 32'(s_q.last_word);
                    end
                end
                OFS_IRQ_STAT:   s_d.hrdata = 32'(s_q.irq_stat);
                OFS_IRQ_MASK:   s_d.hrdata = 32'(s_q.irq_mask);
                default:        s_d.hrdata = 32'h0000_0000;
            endcase
        end

        if (mem_we) begin
            s_d.wr_ptr = s_q.wr_ptr + 1'b1;
        end
        if (pop) begin
            s_d.rd_ptr = s_q.rd_ptr + 1'b1;
        end
        s_d.count = s_q.count + CNT_W'(mem_we) - CNT_W'(pop);

        // reconfiguration or bypass empties the buffer and restarts the pattern
        if (flush || !s_d.fifo_en) begin
            s_d.wr_ptr  = '0;
            s_d.rd_ptr  = '0;
            s_d.count   = '0;
            s_d.dec_cnt = '0;
            s_d.pat_w   = '0;
            s_d.seq     = SFW_IDLE;
        end

        s_d.wm_prev   = wm_flag;
        s_d.full_prev = full;
        ev[IRQ_WM_BIT]   = wm_flag && !s_q.wm_prev;
        ev[IRQ_FULL_BIT] = full && !s_q.full_prev;
        ev[IRQ_OVR_BIT]  = ovr;
        // a new event beats a same-cycle clear
        s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
        s_d.irq      = |(s_d.irq_stat & s_d.irq_mask);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            s_q          <= '0;
            s_q.seq      <= SFW_IDLE;
            s_q.wm_level <= WM_RST;
            s_q.rate_sel <= RATE_RST;
            s_q.dec      <= {NUM_SETS{DEC_RST}};
            s_q.hready   <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // storage has no reset; the pointers make stale words unreachable
    always_ff @(posedge ref_clk) begin
        if (mem_we) begin
            mem[s_q.wr_ptr] <= mem_wd;
        end
    end

    assign hrdata    = s_q.hrdata;
    assign hreadyout = s_q.hready;
    assign hresp     = s_q.hresp;
    assign irq       = s_q.irq;
endmodule // sfw_fifo

// ===== sim/sfw_chk.sv
`timescale 1ns/100ps
module sfw_chk import sfw_pkg::*; #(
    parameter int DEPTH = 4096
) (
    input wire logic        ref_clk,   // clock
    input wire logic        rstn,      // async reset, low
    input wire logic        hsel,      // select
    input wire logic [31:0] haddr,     // address
    input wire logic [1:0]  htrans,    // transfer type
    input wire logic        hwrite,    // direction
    input wire logic [31:0] hwdata,    // write data
    input wire logic        hready,    // bus ready
    input wire logic [31:0] hrdata,    // read data
    input wire logic        hreadyout, // slave ready
    input wire logic        hresp,     // response
    input wire logic        irq        // interrupt
);
    logic       take;
    logic       rd_q;
    logic       wr_q;
    logic [7:0] adr_q;
    logic [2:0] mask_q;
    assign take = hsel && hready && htrans == HTRANS_NONSEQ;
    // mask shadow lets irq be tied to what software last wrote
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            adr_q <= 8'h00;
            mask_q <= 3'h0;
        end else begin
            rd_q <= take && !hwrite;
            wr_q <= take && hwrite;
            if (take) adr_q <= haddr[7:0];
            if (wr_q && adr_q == OFS_IRQ_MASK) mask_q <= hwdata[2:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    chk_wr_wait: assert property (wr_q |-> !hreadyout ##1 hreadyout)
        else $error("write wait state wrong");
    chk_wait_cause: assert property ($fell(hreadyout) |-> $past(hwrite))
        else $error("wait state without write");
    chk_rd_nowait: assert property (rd_q |-> hreadyout && !hresp)
        else $error("read not answered at once");
    chk_unmapped_zero: assert property (rd_q && adr_q > OFS_IRQ_MASK |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    chk_word_width: assert property (rd_q && adr_q == OFS_DATA_OUT |-> hrdata[31:16] == 16'h0)
        else $error("data word wider than 16 bits");
    chk_pattern_width: assert property (rd_q && adr_q == OFS_PATTERN |-> hrdata[31:10] == 22'h0)
        else $error("pattern index wider than 10 bits");
    chk_level_split: assert property (rd_q && adr_q == OFS_CTRL_TWO |-> hrdata[31:4] == 28'h0)
        else $error("upper level bits wrong width");
    chk_count_limit: assert property (rd_q && adr_q == OFS_STATUS_ONE |-> hrdata <= DEPTH)
        else $error("count above depth");
    chk_irq_masked: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq)
        else $error("irq high while masked");
    cover property (wr_q && adr_q == OFS_CTRL_FIVE);
    cover property (rd_q && adr_q == OFS_DATA_OUT);
    cover property ($rose(irq));
endmodule // sfw_chk

// ===== sim/sfw_host.sv
`timescale 1ns/100ps
module sfw_host import sfw_pkg::*; (
    input  wire logic        ref_clk,   // clock
    input  wire logic [31:0] hrdata,    // read data
    input  wire logic        hreadyout, // slave ready
    output logic             hsel,      // select
    output logic      [31:0] haddr,     // address
    output logic      [1:0]  htrans,    // transfer type
    output logic             hwrite,    // direction
    output logic      [2:0]  hsize,     // word size
    output logic      [31:0] hwdata     // write data
);
    logic [31:0] rd_q;
    event        done_ev;
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    // no cycle count assumed: both phases wait for ready
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= HTRANS_NONSEQ;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge ref_clk); while (hreadyout !== 1'b1);
        rd_q = hrdata;
        if (!w) ->done_ev;
    endtask
endmodule // sfw_host

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb import sfw_pkg::*;;
    localparam int DEPTH = 64;
    logic        ref_clk;
    logic        rstn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic [47:0] sd [4];
    logic [63:0] note_q [$];
    int          err_total;
    int          check_count;
    int          seed;
    initial ref_clk = 1'b0;
    always #12.5 ref_clk = ~ref_clk;
    sfw_fifo #(.DEPTH(DEPTH), .TRIG_DIV_104(120), .TRIG_DIV_208(60)) u_sfw_fifo (
        .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .irq(irq), .first_set_xyz(sd[0]),
        .second_set_xyz(sd[1]), .third_set_xyz(sd[2]), .fourth_set_xyz(sd[3]));
    sfw_host u_sfw_host (.ref_clk(ref_clk), .hrdata(hrdata), .hreadyout(hreadyout), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    // a zero mask marks a flow-control read that is not compared
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        note_q.push_back({m, e});
        u_sfw_host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_sfw_host.xfer(1'b1, a, d);
    endtask
    task automatic irq_is(input logic e);
        repeat (3) @(posedge ref_clk);
        #1 cmp_bit(irq, e);
        @(posedge ref_clk);
    endtask
    function automatic logic [15:0] word_of(input int s);
        return sd[s/3][(s%3)*16 +: 16];
    endfunction
    function automatic int sel_of(input int c, input int i);
        case (c)
            1: return (i < 6) ? i : i - 6;
            2: return (i < 12) ? ((i < 9) ? i : i - 6) : ((i < 18) ? i - 12 : i - 15);
            3: return i + 9;
            default: return i;
        endcase
    endfunction
    task automatic run_pat(input int cfg, input logic [7:0] c3, c4, c5, input int len);
        int idx;
        int k;
        idx = 0;
        k = 0;
        for (int i = 0; i < 4; i++) sd[i] <= 48'({$random(seed), $random(seed)});
        wr(OFS_CTRL_THREE, {24'h0, c3});
        wr(OFS_CTRL_FOUR, {24'h0, c4});
        wr(OFS_CTRL_FIVE, {24'h0, c5});
        while (k < len + 4) begin
            rd(OFS_STATUS_ONE, 32'h0, 32'h0);
            if (u_sfw_host.rd_q != 32'h0) begin
                rd(OFS_PATTERN, 32'(idx), 32'h3FF);
                rd(OFS_DATA_OUT, {16'h0, word_of(sel_of(cfg, idx))}, 32'hFFFF);
                idx = (idx + 1) % len;
                k++;
            end
        end
    endtask
    task automatic finish_test();
        $display("errors %0d checks %0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        logic [63:0] n;
        forever begin
            @(u_sfw_host.done_ev);
            n = note_q.pop_front();
            if (n[63:32] != 32'h0) cmp_word(u_sfw_host.rd_q & n[63:32], n[31:0]);
        end
    end
    initial begin
        #1000000;
        err_total++;
        finish_test();
    end
    initial begin
        err_total = 0;
        check_count = 0;
        seed = 65;
        rstn = 1'b0;
        for (int i = 0; i < 4; i++) sd[i] = 48'h0;
        repeat (12) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        rd(OFS_STATUS_TWO, 32'h5, 32'hF);
        rd(8'h40, 32'h0, 32'hFFFFFFFF);
        wr(OFS_STATUS_ONE, 32'hFFF);
        rd(OFS_STATUS_ONE, 32'h0, 32'hFFFFFFFF);
        wr(OFS_CTRL_ONE, 32'hFF);
        wr(OFS_CTRL_TWO, 32'hFF);
        rd(OFS_CTRL_ONE, 32'hFF, 32'hFFFFFFFF);
        rd(OFS_CTRL_TWO, 32'hF, 32'hFFFFFFFF);
        run_pat(0, 8'h09, 8'h00, 8'h14, 6);
        run_pat(1, 8'h11, 8'h00, 8'h15, 9);
        run_pat(2, 8'h0A, 8'h04, 8'h15, 21);
        run_pat(3, 8'h00, 8'h08, 8'h14, 3);
        // rate check: same config, twice the trigger rate gives twice the words
        wr(OFS_CTRL_THREE, 32'h09);
        wr(OFS_CTRL_FOUR, 32'h0);
        wr(OFS_CTRL_FIVE, 32'h14);
        repeat (360) @(posedge ref_clk);
        rd(OFS_STATUS_ONE, 32'h0, 32'h0);
        cmp_bit(u_sfw_host.rd_q inside {[12:24]}, 1'b1);
        wr(OFS_CTRL_FIVE, 32'h15);
        repeat (360) @(posedge ref_clk);
        rd(OFS_STATUS_ONE, 32'h0, 32'h0);
        cmp_bit(u_sfw_host.rd_q inside {[30:48]}, 1'b1);
        wr(OFS_CTRL_ONE, 32'd21);
        wr(OFS_CTRL_TWO, 32'h0);
        wr(OFS_COMMON_C4, 32'h1);
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_CTRL_FIVE, 32'h15);
        repeat (300) @(posedge ref_clk);
        rd(OFS_STATUS_ONE, 32'd21, 32'hFFFFFFFF);
        rd(OFS_STATUS_TWO, 32'hB, 32'hF);
        rd(OFS_IRQ_STAT, 32'h7, 32'h7);
        wr(OFS_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(OFS_IRQ_MASK, 32'h0);
        irq_is(1'b0);
        wr(OFS_IRQ_STAT, 32'h7);
        wr(OFS_IRQ_MASK, 32'h3);
        irq_is(1'b0);
        // a dropped word needs a trigger after the clear
        repeat (80) @(posedge ref_clk);
        rd(OFS_IRQ_STAT, 32'h4, 32'h7);
        wr(OFS_COMMON_C4, 32'h0);
        repeat (600) @(posedge ref_clk);
        rd(OFS_STATUS_ONE, 32'(DEPTH), 32'hFFFFFFFF);
        irq_is(1'b1);
        wr(OFS_CTRL_FIVE, 32'h0);
        rd(OFS_STATUS_ONE, 32'h0, 32'hFFFFFFFF);
        rd(OFS_PATTERN, 32'h0, 32'h3FF);
        rd(OFS_STATUS_TWO, 32'h4, 32'h6);
        // disabled read repeats the last popped word, fourth set x
        rd(OFS_DATA_OUT, {16'h0, word_of(9)}, 32'hFFFF);
        finish_test();
    end
endmodule // tb
bind sfw_fifo sfw_chk #(.DEPTH(DEPTH)) u_sfw_chk (
    .ref_clk(ref_clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
